// ===== rtl/peripheral_module_disable.sv
// Peripheral module disable controller with APB register access
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "pmd_defines.svh"
module peripheral_module_disable (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [39:0] modClkEn,
	output logic [39:0] modResetHold,
	output logic [39:0] modIsolate,
	output logic [39:0] modActive
);
	import pmd_pkg::*;

	logic [7:0] ctrl_ff [0:4];
	logic [7:0] nxt_ctrl [0:4];
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic pready_ff;
	logic nxt_pready;
	logic pslverr_ff;
	logic nxt_pslverr;
	reg_idx_t regIdx;
	logic regHit;
	logic [7:0] wrMask;
	logic [7:0] rdSel;
	logic setupPhase;
	logic wrAccess;
	logic [39:0] disableVec;

	assign setupPhase = psel && !penable;
	assign wrAccess = psel && penable && pready_ff && pwrite;

	always_comb begin
		regHit = 1'b0;
		regIdx = 3'h0;
		wrMask = 8'h00;
		case (paddr)
			`PMD_OFS_CTRL0: begin
				regHit = 1'b1;
				regIdx = 3'h0;
				wrMask = `PMD_WMASK_CTRL0;
			end
			`PMD_OFS_CTRL1: begin
				regHit = 1'b1;
				regIdx = 3'h1;
				wrMask = `PMD_WMASK_CTRL1;
			end
			`PMD_OFS_CTRL2: begin
				regHit = 1'b1;
				regIdx = 3'h2;
				wrMask = `PMD_WMASK_CTRL2;
			end
			`PMD_OFS_CTRL3: begin
				regHit = 1'b1;
				regIdx = 3'h3;
				wrMask = `PMD_WMASK_CTRL3;
			end
			`PMD_OFS_CTRL4: begin
				regHit = 1'b1;
				regIdx = 3'h4;
				wrMask = `PMD_WMASK_CTRL4;
			end
			default: begin
				regHit = 1'b0;
			end
		endcase
	end

	assign rdSel = regHit ? ctrl_ff[regIdx] : 8'h00;

	// Only byte lane 0 carries a register; upper lanes are ignored
	always_comb begin
		for (int i = 0; i < `PMD_NUM_REGS; i++) begin
			nxt_ctrl[i] = ctrl_ff[i];
			if (wrAccess && regHit && pstrb[0] && (regIdx == 3'(i))) begin
				nxt_ctrl[i] = pwdata[7:0] & wrMask;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < `PMD_NUM_REGS; i++) begin
				ctrl_ff[i] <= `PMD_RST_CTRL;
			end
		end else begin
			for (int i = 0; i < `PMD_NUM_REGS; i++) begin
				ctrl_ff[i] <= nxt_ctrl[i];
			end
		end
	end

	// Answer prepared in the setup cycle, so every access has no wait state
	always_comb begin
		nxt_pready = setupPhase;
		nxt_pslverr = setupPhase && !regHit;
		nxt_prdata = 32'h00000000;
		if (setupPhase && !pwrite) begin
			nxt_prdata = {24'h000000, rdSel};
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
		end else begin
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff <= nxt_prdata;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	assign disableVec = {ctrl_ff[4], ctrl_ff[3], ctrl_ff[2], ctrl_ff[1], ctrl_ff[0]};

	// Bit 7 of control 0 drives the shared peripheral clock net gate
	// Bit 2 of control 0 isolates the memory controller and its pointer path
	for (genvar g = 0; g < `PMD_NUM_BITS; g++) begin : gen_cell
		// Memory wakes slower; software is told to wait, this covers it too
		localparam wake_cnt_t WAKE = (g == `PMD_BIT_NVM) ?
			5'(`PMD_NVM_WAKE_CYC) : 5'(`PMD_INSTR_WAKE_CYC);
		module_gate_cell #(
			.WAKE_CYC(WAKE)
		) u_cell (
			.clk_sys(clk_sys),
			.reset_n(reset_n),
			.modOff(disableVec[g]),
			.clkEn_ff(modClkEn[g]),
			.resetHold_ff(modResetHold[g]),
			.isolate_ff(modIsolate[g]),
			.active_ff(modActive[g])
		);
	end

	AST_RESET_CLEAR: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$rose(reset_n) |-> (disableVec == 40'h0000000000) && (modActive == {40{1'b1}}))
		else $error("modules not all enabled after reset");

	AST_WRITE_MASK: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wrAccess && regHit && pstrb[0])
		|=> ctrl_ff[$past(regIdx)] == ($past(pwdata[7:0]) & $past(wrMask)))
		else $error("register write not stored through mask");

	AST_RSVD_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n)
		((ctrl_ff[0] & ~`PMD_WMASK_CTRL0) == 8'h00)
		&& ((ctrl_ff[2] & ~`PMD_WMASK_CTRL2) == 8'h00)
		&& ((ctrl_ff[4] & ~`PMD_WMASK_CTRL4) == 8'h00))
		else $error("unimplemented bit reads nonzero");

	AST_READBACK: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(setupPhase && !pwrite && regHit) |=> pready_ff && (prdata_ff == {24'h000000, $past(rdSel)}))
		else $error("read data does not match register");

	AST_UNMAPPED: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(setupPhase && !regHit) |=> pready_ff && pslverr_ff && (prdata_ff == 32'h00000000))
		else $error("unmapped access not answered with error");

	AST_SYSCLK_CUT: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctrl_ff[0][7] ##1 ctrl_ff[0][7] |-> !modClkEn[`PMD_BIT_SYSCLK])
		else $error("peripheral system clock not cut");

	AST_NVM_BLOCK: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctrl_ff[0][2] |=> modIsolate[`PMD_BIT_NVM] && modResetHold[`PMD_BIT_NVM])
		else $error("memory access not blocked while disabled");

	AST_GATE_LAG: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$rose(ctrl_ff[1][0]) |-> modClkEn[8] ##1 !modClkEn[8])
		else $error("gate control not one registered stage behind");

	AST_TIMER_OFF: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctrl_ff[1][6] |=> modIsolate[14] && !modActive[14])
		else $error("timer not isolated while disabled");

	// Bus answer stands only in the cycle after a setup cycle
	AST_READY_AFTER_SETUP: assert property (@(posedge clk_sys) disable iff (!reset_n)
		pready_ff
		|-> $past(setupPhase))
		else $error("ready raised without a setup cycle");

	AST_ERR_WITH_READY: assert property (@(posedge clk_sys) disable iff (!reset_n)
		pslverr_ff
		|-> pready_ff)
		else $error("error flag raised outside an access cycle");

	AST_RDATA_IDLE: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!pready_ff
		|-> prdata_ff == 32'h00000000)
		else $error("read data not zero outside an access cycle");

	AST_WRITE_NO_DATA: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(setupPhase && pwrite)
		|=> prdata_ff == 32'h00000000)
		else $error("write access returned read data");

	AST_CTRL_QUIET: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!(wrAccess && regHit && pstrb[0])
		|=> disableVec == $past(disableVec))
		else $error("control register changed without a write");

	AST_STRB_IGNORED: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wrAccess && !pstrb[0])
		|=> disableVec == $past(disableVec))
		else $error("write without lane strobe changed a register");

	AST_UNMAPPED_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wrAccess && !regHit)
		|=> disableVec == $past(disableVec))
		else $error("unmapped write changed a register");

	AST_CTRL0_OFF: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctrl_ff[0] != 8'h00
		|=> (modIsolate[7:0] & $past(ctrl_ff[0])) == $past(ctrl_ff[0]))
		else $error("control 0 module not isolated");

	AST_CTRL1_OFF: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctrl_ff[1] != 8'h00
		|=> (modResetHold[15:8] & $past(ctrl_ff[1])) == $past(ctrl_ff[1]))
		else $error("control 1 module not held in reset");

	AST_CTRL2_OFF: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctrl_ff[2] != 8'h00
		|=> (modClkEn[23:16] & $past(ctrl_ff[2])) == 8'h00)
		else $error("control 2 module clock still running");

	AST_CTRL3_OFF: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctrl_ff[3] != 8'h00
		|=> (modIsolate[31:24] & $past(ctrl_ff[3])) == $past(ctrl_ff[3]))
		else $error("control 3 module not isolated");

	AST_CTRL4_OFF: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctrl_ff[4] != 8'h00
		|=> (modActive[39:32] & $past(ctrl_ff[4])) == 8'h00)
		else $error("control 4 module still active");

	// Positions with no module behind them must never leave the run state
	AST_RSVD_RUN: assert property (@(posedge clk_sys) disable iff (!reset_n)
		&(modActive | {`PMD_WMASK_CTRL4, `PMD_WMASK_CTRL3, `PMD_WMASK_CTRL2,
		`PMD_WMASK_CTRL1, `PMD_WMASK_CTRL0}))
		else $error("unimplemented position left run state");

	AST_RSVD_OPEN: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(modIsolate & ~{`PMD_WMASK_CTRL4, `PMD_WMASK_CTRL3, `PMD_WMASK_CTRL2,
		`PMD_WMASK_CTRL1, `PMD_WMASK_CTRL0}) == 40'h0000000000)
		else $error("unimplemented position isolated");

	AST_SYSCLK_BACK: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$fell(ctrl_ff[0][7])
		|=> modClkEn[`PMD_BIT_SYSCLK])
		else $error("peripheral system clock not restored");

	AST_TIMER0_EARLY: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$fell(ctrl_ff[1][0])
		|-> ##4 !modActive[8])
		else $error("timer left reset before its wake interval");

	AST_TIMER0_WAKE: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$fell(ctrl_ff[1][0]) ##1 (!ctrl_ff[1][0]) [*4]
		|=> modActive[8])
		else $error("timer not active one instruction after enable");

	AST_NVM_EARLY: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$fell(ctrl_ff[0][2])
		|-> ##20 !modActive[`PMD_BIT_NVM])
		else $error("memory left reset before its wake interval");

	AST_NVM_WAKE: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$fell(ctrl_ff[0][2]) ##1 (!ctrl_ff[0][2]) [*8] ##1 (!ctrl_ff[0][2]) [*8]
		##1 (!ctrl_ff[0][2]) [*4]
		|=> modActive[`PMD_BIT_NVM] && !modIsolate[`PMD_BIT_NVM])
		else $error("memory not active after its wake interval");

	AST_SERIAL_OFF: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctrl_ff[4][5]
		|=> modResetHold[37] && !modClkEn[37])
		else $error("async serial unit not stopped");

	AST_OSC_OFF: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctrl_ff[1][7]
		|=> modIsolate[15] && !modActive[15])
		else $error("oscillator not isolated while disabled");
endmodule // peripheral_module_disable
`default_nettype wire

// ===== rtl/pmd_defines.svh
// Register offsets, field positions, reset values and timing counts of the module disable block
`ifndef PMD_DEFINES_SVH
`define PMD_DEFINES_SVH

`define PMD_ADDR_W 12
`define PMD_NUM_REGS 5
`define PMD_NUM_BITS 40

`define PMD_OFS_CTRL0 12'h000
`define PMD_OFS_CTRL1 12'h004
`define PMD_OFS_CTRL2 12'h008
`define PMD_OFS_CTRL3 12'h00C
`define PMD_OFS_CTRL4 12'h010

`define PMD_RST_CTRL 8'h00

`define PMD_WMASK_CTRL0 8'hC7
`define PMD_WMASK_CTRL1 8'hFF
`define PMD_WMASK_CTRL2 8'h66
`define PMD_WMASK_CTRL3 8'hFF
`define PMD_WMASK_CTRL4 8'h26

// Positions in the flat disable vector: register index times eight plus bit
`define PMD_BIT_SYSCLK 7
`define PMD_BIT_VREF 6
`define PMD_BIT_NVM 2
`define PMD_BIT_CLKREF 1
`define PMD_BIT_PINCHG 0

`define PMD_CLK_PERIOD_NS 50
`define PMD_INSTR_CYCLE_NS 200
`define PMD_NVM_WAKE_NS 1000
`define PMD_INSTR_WAKE_CYC (`PMD_INSTR_CYCLE_NS / `PMD_CLK_PERIOD_NS)
`define PMD_NVM_WAKE_CYC (`PMD_NVM_WAKE_NS / `PMD_CLK_PERIOD_NS)

`endif

// ===== rtl/pmd_pkg.sv
// Types shared by the module disable block
package pmd_pkg;
	typedef enum logic [1:0] {
		CELL_RUN = 2'b00,
		CELL_OFF = 2'b01,
		CELL_WAKE = 2'b10
	} cell_state_t;
	typedef logic [2:0] reg_idx_t;
	typedef logic [4:0] wake_cnt_t;
endpackage

// ===== rtl/module_gate_cell.sv
// One peripheral's clock gate, reset hold and isolation sequencer
`timescale 1ns/100ps
`default_nettype none
module module_gate_cell #(
	parameter pmd_pkg::wake_cnt_t WAKE_CYC = 5'h04
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic modOff,
	output logic clkEn_ff,
	output logic resetHold_ff,
	output logic isolate_ff,
	output logic active_ff
);
	import pmd_pkg::*;

	cell_state_t state_ff, nxt_state;
	wake_cnt_t cnt_ff, nxt_cnt;
	logic nxt_clkEn, nxt_resetHold, nxt_isolate, nxt_active;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			CELL_RUN: begin
				if (modOff) begin
					nxt_state = CELL_OFF;
				end
			end
			CELL_OFF: begin
				if (!modOff) begin
					nxt_state = CELL_WAKE;
					nxt_cnt = WAKE_CYC - 5'h01;
				end
			end
			CELL_WAKE: begin
				if (modOff) begin
					nxt_state = CELL_OFF;
				end else if (cnt_ff == 5'h00) begin
					nxt_state = CELL_RUN;
				end else begin
					nxt_cnt = cnt_ff - 5'h01;
				end
			end
			default: begin
				nxt_state = CELL_RUN;
			end
		endcase
		// Clock runs during wake so the held reset is taken by clocked logic
		nxt_clkEn = (nxt_state != CELL_OFF);
		nxt_resetHold = (nxt_state != CELL_RUN);
		nxt_isolate = (nxt_state != CELL_RUN);
		nxt_active = (nxt_state == CELL_RUN);
	end

	// Registered controls keep the gate enable free of decode glitches
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= CELL_RUN;
			cnt_ff <= 5'h00;
			clkEn_ff <= 1'b1;
			resetHold_ff <= 1'b0;
			isolate_ff <= 1'b0;
			active_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			clkEn_ff <= nxt_clkEn;
			resetHold_ff <= nxt_resetHold;
			isolate_ff <= nxt_isolate;
			active_ff <= nxt_active;
		end
	end

	AST_OFF_HOLDS: assert property (@(posedge clk_sys) disable iff (!reset_n)
		modOff |=> !clkEn_ff && resetHold_ff && isolate_ff && !active_ff)
		else $error("disabled module not stopped and held");

	AST_WAKE_IN_RESET: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$fell(modOff) |=> clkEn_ff && resetHold_ff && !active_ff)
		else $error("re-enabled module not in reset with clock");

	AST_WAKE_BOUND: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$fell(modOff) |-> ##[1:32] (active_ff || modOff))
		else $error("module did not become active in time");

	AST_ACTIVE_CLEAN: assert property (@(posedge clk_sys) disable iff (!reset_n)
		active_ff |-> clkEn_ff && !resetHold_ff && !isolate_ff)
		else $error("active module still isolated");
endmodule // module_gate_cell
`default_nettype wire

// ===== dv/periph_model.sv
// Behavioural peripherals behind the clock gates and reset holds
`timescale 1ns/100ps
`default_nettype none
module periph_model (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [39:0] clkEn,
	input wire logic [39:0] resetHold,
	input wire logic [39:0] isolate,
	output logic [39:0] digOut
);
	logic [39:0] phase_ff;
	// A held module sits at its reset value; a gated one keeps still
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			phase_ff <= 40'h0;
		end else begin
			for (int i = 0; i < 40; i++) begin
				if (resetHold[i]) begin
					phase_ff[i] <= 1'b0;
				end else if (clkEn[i]) begin
					phase_ff[i] <= ~phase_ff[i];
				end
			end
		end
	end
	assign digOut = phase_ff & ~isolate;
endmodule // periph_model
`default_nettype wire

// ===== dv/peripheral_module_disable_tb_top.sv
// Self-checking bench of the module disable block
`timescale 1ns/100ps
`default_nettype none
`include "pmd_defines.svh"
module peripheral_module_disable_tb_top;
	logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic [39:0] modClkEn, modResetHold, modIsolate, modActive, digOut;
	logic [9:0] expq[$];
	logic [9:0] note;
	logic [31:0] rnd;
	logic [7:0] msk[5] = '{`PMD_WMASK_CTRL0, `PMD_WMASK_CTRL1, `PMD_WMASK_CTRL2,
		`PMD_WMASK_CTRL3, `PMD_WMASK_CTRL4};
	int num_errors = 0;
	int total_checks = 0;
	peripheral_module_disable DUT (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .modClkEn(modClkEn),
		.modResetHold(modResetHold), .modIsolate(modIsolate), .modActive(modActive));
	periph_model partner (.clk_sys(clk_sys), .reset_n(reset_n), .clkEn(modClkEn),
		.resetHold(modResetHold), .isolate(modIsolate), .digOut(digOut));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic stop_test();
		if (num_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [39:0] e, input logic [39:0] s);
		total_checks++;
		if (s !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, s);
			num_errors++;
		end
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [11:0] ad(input int i);
		return 12'(`PMD_OFS_CTRL0 + 4 * i);
	endfunction
	// Called right after an edge; one idle edge follows so strobes never double-assign
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
		input logic err);
		expq.push_back({wr, err, wr ? 8'h00 : d});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		// No wait limit here: only the watchdog ends a stalled access
		do @(posedge clk_sys); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	always @(posedge clk_sys) begin
		if (psel && penable && pready === 1'b1) begin
			note = expq.pop_front();
			check("pslverr", {39'h0, note[8]}, {39'h0, pslverr});
			if (!note[9]) begin
				check("prdata", {32'h0, note[7:0]}, {8'h00, prdata});
			end
		end
	end
	task automatic vecs(input logic [39:0] off);
		@(posedge clk_sys);
		#1;
		check("modClkEn", ~off, modClkEn);
		check("modResetHold", off, modResetHold);
		check("modIsolate", off, modIsolate);
		check("modActive", ~off, modActive);
		check("digOut", 40'h0, digOut & off);
		@(posedge clk_sys);
	endtask
	// Clear a whole register and time the return of one module
	task automatic wake(input int r, input int idx, input int n);
		apb(1'b1, ad(r), 8'h00, 1'b0);
		#1;
		check("clkEn wake", 40'h1, {39'h0, modClkEn[idx]});
		check("hold wake", 40'h1, {39'h0, modResetHold[idx]});
		repeat (n - 1) @(posedge clk_sys);
		#1;
		check("active early", 40'h0, {39'h0, modActive[idx]});
		@(posedge clk_sys);
		#1;
		check("active", 40'h1, {39'h0, modActive[idx] & ~modIsolate[idx]});
		@(posedge clk_sys);
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		stop_test();
	end
	initial begin
		reset_n = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		pstrb = 4'hF;
		rnd = 32'h00014478;
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 5; i++) apb(1'b0, ad(i), 8'h00, 1'b0);
		vecs(40'h0);
		for (int i = 0; i < 5; i++) apb(1'b1, ad(i), 8'hFF, 1'b0);
		for (int i = 0; i < 5; i++) apb(1'b0, ad(i), msk[i], 1'b0);
		vecs({msk[4], msk[3], msk[2], msk[1], msk[0]});
		apb(1'b0, 12'h014, 8'h00, 1'b1);
		apb(1'b1, 12'h020, 8'hFF, 1'b1);
		pstrb <= 4'hE;
		apb(1'b1, ad(3), 8'h00, 1'b0);
		pstrb <= 4'hF;
		apb(1'b0, ad(3), 8'hFF, 1'b0);
		wake(1, 8, 4);
		wake(0, 2, 20);
		for (int i = 0; i < 10; i++) begin
			rnd = lfsr(rnd);
			apb(1'b1, ad(i % 5), rnd[7:0], 1'b0);
			apb(1'b0, ad(i % 5), rnd[7:0] & msk[i % 5], 1'b0);
		end
		// Reset in mid-run must drop every disable at once
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 5; i++) apb(1'b0, ad(i), 8'h00, 1'b0);
		vecs(40'h0);
		check("pending notes", 40'h0, 40'(expq.size()));
		stop_test();
	end
endmodule // peripheral_module_disable_tb_top
`default_nettype wire
